/* sim/spbg_chk_sva.sv */
// Purpose: Port-level checks of the serial port top
// Assumes: One clock domain, synchronous active-low reset
// Notes: Bound into every spbg_top instance
`timescale 1ns/10ps
`include "spbg_consts.svh"
module spbg_chk
(
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_rst_n,
   // Avalon-MM slave
   input wire logic [4:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   input wire logic [31:0] o_avs_readdata,
   input wire logic o_avs_waitrequest,
   // Serial link and interrupt
   input wire logic i_rxd,
   input wire logic o_txd,
   input wire logic o_irq
);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rst_n);
   ////////////////////////////////////////
   sequence s_rd_wait;
      o_avs_waitrequest ##1 !o_avs_waitrequest;
   endsequence
   sequence s_mask_off;
      i_avs_write && i_avs_address == `SPBG_OFF_IMASK && i_avs_byteenable[0]
         && i_avs_writedata[2:0] == 3'h0;
   endsequence
   ////////////////////////////////////////
   AST_WR_NOWAIT: assert property (i_avs_write |-> !o_avs_waitrequest)
      else $error("write was stalled");
   AST_READ_ONEWAIT: assert property ($rose(i_avs_read) |-> s_rd_wait)
      else $error("read did not take exactly one wait");
   AST_IDLE_NOWAIT: assert property (!i_avs_read |-> !o_avs_waitrequest)
      else $error("wait without a read");
   AST_RDATA_HOLD: assert property (!i_avs_read && !$past(i_avs_read) |-> $stable(o_avs_readdata))
      else $error("read data moved without a read");
   AST_UNMAPPED_RD: assert property (i_avs_read && !o_avs_waitrequest && i_avs_address == 5'h1c
      |-> o_avs_readdata == 32'h0)
      else $error("unmapped read not zero");
   AST_IRQ_MASKED: assert property (s_mask_off |=> !o_irq)
      else $error("irq high with all causes masked");
   // Shortest bit is two timer overflows of one clock each
   AST_TXD_MINBIT: assert property ($changed(o_txd) |=> $stable(o_txd))
      else $error("txd level shorter than a bit");
   AST_RESET_IDLE: assert property (disable iff (1'b0) !i_rst_n |=> o_txd && !o_irq)
      else $error("outputs not idle after reset");
   COV_IRQ: cover property ($rose(o_irq));
endmodule // spbg_chk

bind spbg_top spbg_chk chk_u (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
   .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
   .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
   .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
   .i_rxd(i_rxd), .o_txd(o_txd), .o_irq(o_irq));

/* sim/spbg_peer.sv */
// Purpose: Remote serial peer, sends and receives 8N1 characters
// Assumes: Bit time in clocks set by the bench before traffic
// Notes: Line idles high; receiver keeps the last good byte
`timescale 1ns/10ps
module spbg_peer
(
   // Clock
   input wire logic i_mclk,
   // Serial link
   input wire logic i_txd,
   output logic o_rxd
);
   int bit_clks = 16;
   int got_cnt = 0;
   logic [7:0] got_byte = 8'h00;
   logic [7:0] shf;
   initial o_rxd = 1'b1;
   ////////////////////////////////////////
   // start, LSB first, stop
   task send_byte(input logic [7:0] b);
      int i;
      @(posedge i_mclk);
      o_rxd <= 1'b0;
      repeat (bit_clks) @(posedge i_mclk);
      for (i = 0; i < 8; i++)
      begin
         o_rxd <= b[i];
         repeat (bit_clks) @(posedge i_mclk);
      end
      o_rxd <= 1'b1;
      repeat (bit_clks) @(posedge i_mclk);
   endtask
   ////////////////////////////////////////
   // mid-bit sampling
   always
   begin
      @(negedge i_txd);
      repeat (bit_clks / 2) @(posedge i_mclk);
      if (i_txd === 1'b0)
      begin
         for (int j = 0; j < 8; j++)
         begin
            repeat (bit_clks) @(posedge i_mclk);
            shf[j] = i_txd;
         end
         repeat (bit_clks) @(posedge i_mclk);
         // Bad stop bit drops the character
         if (i_txd === 1'b1)
         begin
            got_byte = shf;
            got_cnt++;
         end
      end
   end
endmodule // spbg_peer

/* sim/tb.sv */
// Purpose: Self-checking bench of the serial port over Avalon-MM
// Assumes: Reads take one wait, writes none
// Notes: Bus requests change only after a rising edge
`timescale 1ns/10ps
`include "spbg_consts.svh"
module tb;
   logic clk = 1'b0;
   logic rst_n, rd, wr, rxd, txd, irq, wait_rq;
   logic [4:0] addr;
   logic [31:0] wdata, rdata, q;
   logic [3:0] be;
   int err_count = 0;
   int samples_checked = 0;
   int n;
   logic [4:0] offs [7] = '{5'h04, 5'h08, 5'h0c, 5'h10, 5'h14, 5'h18, 5'h1c};
   logic [7:0] rx_pat [4] = '{8'h11, 8'h22, 8'h33, 8'h44};
   int divs [4] = '{1, 4, 12, 48};
   always #4 clk = ~clk;
   spbg_top dut_u (.i_mclk(clk), .i_rst_n(rst_n), .i_avs_address(addr), .i_avs_read(rd),
      .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(be),
      .o_avs_readdata(rdata), .o_avs_waitrequest(wait_rq), .i_rxd(rxd), .o_txd(txd),
      .o_irq(irq));
   spbg_peer peer_u (.i_mclk(clk), .i_txd(txd), .o_rxd(rxd));
   ////////////////////////////////////////
   task stop_test;
      if (err_count == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         $display("BAD %s exp %h got %h", name, exp, got);
         err_count++;
      end
   endtask
   // Request held until waitrequest is seen low
   task bus(input logic w, input logic [4:0] a, input logic [31:0] d, input logic [3:0] b,
      output logic [31:0] r);
      int k;
      @(posedge clk);
      addr <= a;
      wdata <= d;
      be <= b;
      wr <= w;
      rd <= !w;
      k = 0;
      do
      begin
         @(posedge clk);
         k++;
      end
      while (wait_rq !== 1'b0 && k < 20);
      chk("waitrequest", 32'h0, {31'h0, wait_rq});
      r = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
      // Let side effects of the accept edge settle before callers look
      @(negedge clk);
   endtask
   task wr_reg(input logic [4:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, 4'hf, r);
   endtask
   task rd_chk(input string name, input logic [4:0] a, input logic [31:0] exp);
      logic [31:0] r;
      bus(1'b0, a, 32'h0, 4'hf, r);
      chk(name, exp, r);
   endtask
   task wait_txdone;
      logic [31:0] r;
      int k;
      k = 0;
      r = 32'h0;
      while (r[`SPBG_CTRL_TXDONE] !== 1'b1 && k < 2000)
      begin
         bus(1'b0, `SPBG_OFF_CTRL, 32'h0, 4'hf, r);
         k++;
      end
      chk("tx done wait", 32'h1, {31'h0, r[`SPBG_CTRL_TXDONE]});
   endtask
   ////////////////////////////////////////
   initial
   begin
      repeat (40000) @(posedge clk);
      err_count++;
      stop_test;
   end
   initial
   begin
      rst_n = 1'b0;
      rd = 1'b0;
      wr = 1'b0;
      addr = 5'h00;
      wdata = 32'h0;
      be = 4'h0;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      wr_reg(5'h1c, 32'hff);
      bus(1'b1, `SPBG_OFF_IMASK, 32'h7, 4'he, q);
      foreach (offs[i]) rd_chk("reset value", offs[i], 32'h0);
      // Generator off: held byte must not leave
      wr_reg(`SPBG_OFF_DATA, 32'h55);
      repeat (300) @(posedge clk);
      chk("peer count", 32'h0, peer_u.got_cnt);
      chk("txd idle", 32'h1, {31'h0, txd});
      // Sixteen clocks a bit keeps the rate at the recommended limit
      wr_reg(`SPBG_OFF_RLDL, 32'hf8);
      wr_reg(`SPBG_OFF_RLDH, 32'hff);
      wr_reg(`SPBG_OFF_IMASK, 32'h7);
      wr_reg(`SPBG_OFF_BAUD, 32'h3);
      wait_txdone;
      chk("peer byte", 32'h55, {24'h0, peer_u.got_byte});
      chk("irq tx", 32'h1, {31'h0, irq});
      rd_chk("istat tx", `SPBG_OFF_ISTAT, 32'h1);
      chk("irq after read", 32'h0, {31'h0, irq});
      rd_chk("ctrl kept", `SPBG_OFF_CTRL, 32'h1);
      wr_reg(`SPBG_OFF_CTRL, 32'h0);
      rd_chk("ctrl cleared", `SPBG_OFF_CTRL, 32'h0);
      // Four bytes into a three-byte FIFO
      foreach (rx_pat[i]) peer_u.send_byte(rx_pat[i]);
      repeat (32) @(posedge clk);
      rd_chk("ctrl full", `SPBG_OFF_CTRL, 32'h36);
      chk("irq rx", 32'h1, {31'h0, irq});
      wr_reg(`SPBG_OFF_IMASK, 32'h0);
      chk("irq masked", 32'h0, {31'h0, irq});
      wr_reg(`SPBG_OFF_CTRL, 32'h0);
      rd_chk("ctrl held", `SPBG_OFF_CTRL, 32'h32);
      for (int i = 0; i < 3; i++) rd_chk("fifo data", `SPBG_OFF_DATA, {24'h0, rx_pat[i]});
      rd_chk("ctrl drained", `SPBG_OFF_CTRL, 32'h2);
      wr_reg(`SPBG_OFF_CTRL, 32'h0);
      rd_chk("ctrl rx clear", `SPBG_OFF_CTRL, 32'h0);
      rd_chk("istat rx", `SPBG_OFF_ISTAT, 32'h6);
      // Prescaler sweep, timer four counts from reload
      wr_reg(`SPBG_OFF_RLDL, 32'hfc);
      for (int k = 0; k < 4; k++)
      begin
         wr_reg(`SPBG_OFF_BAUD, {28'h0, k[1:0], 2'b01});
         peer_u.bit_clks = 8 * divs[k];
         repeat (24 * divs[k]) @(posedge clk);
         wr_reg(`SPBG_OFF_DATA, 32'h1);
         n = 0;
         while (txd !== 1'b0 && n < 1000)
         begin
            @(negedge clk);
            n++;
         end
         n = 0;
         while (txd === 1'b0 && n < 1000)
         begin
            @(negedge clk);
            n++;
         end
         chk("start bit clocks", 8 * divs[k], n);
         wait_txdone;
         chk("peer byte div", 32'h1, {24'h0, peer_u.got_byte});
         chk("peer count div", k + 2, peer_u.got_cnt);
         wr_reg(`SPBG_OFF_CTRL, 32'h0);
      end
      stop_test;
   end
endmodule // tb

/* src/spbg_baud.sv */
// Purpose: Baud generator, prescaler and 16-bit reload timer
// Assumes: Settings held stable by the register file
// Notes: One tick per timer overflow, two ticks per bit
`timescale 1ns/10ps
`include "spbg_consts.svh"
module spbg_baud
   import spbg_pkg::*;
(
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_rst_n,
   // Settings and tick
   spbg_baud_if.gen bif
);

   logic [5:0] ps_cnt;
   logic [5:0] ps_max;
   logic ps_tick;
   logic clk_tick;
   logic [15:0] timer;
   logic ovf;

   ////////////////////////////////////////////////////////////////////////////
   // Prescaler select
   assign ps_max = (bif.prescale == PS_DIV1) ? `SPBG_DIV1 :
                   (bif.prescale == PS_DIV4) ? `SPBG_DIV4 :
                   (bif.prescale == PS_DIV12) ? `SPBG_DIV12 : `SPBG_DIV48;
   assign ps_tick = (ps_cnt >= ps_max);
   assign clk_tick = bif.src_direct | ps_tick;
   assign ovf = bif.enable & clk_tick & (timer == 16'hffff);
   assign bif.tick = ovf;

   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n || !bif.enable || ps_tick)
      begin
         ps_cnt <= 6'h00;
      end
      else
      begin
         ps_cnt <= ps_cnt + 6'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Idle generator holds the reload so counting starts from it
   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
      begin
         timer <= `SPBG_RST_RELOAD;
      end
      else if (!bif.enable || ovf)
      begin
         timer <= bif.reload;
      end
      else if (clk_tick)
      begin
         timer <= timer + 16'h0001;
      end
   end

endmodule // spbg_baud

/* src/spbg_baud_if.sv */
// Purpose: Carries baud generator settings and its tick
// Assumes: Single clock domain
// Notes: ctrl side is the port, gen side the timer
`timescale 1ns/10ps
interface spbg_baud_if;
   import spbg_pkg::*;
   logic enable;
   logic src_direct;
   spbg_ps_e prescale;
   logic [15:0] reload;
   logic tick;
   modport ctrl (output enable, output src_direct, output prescale, output reload, input tick);
   modport gen (input enable, input src_direct, input prescale, input reload, output tick);
endinterface

/* src/spbg_consts.svh */
// Purpose: Offsets, field positions, reset values and timing counts of the serial port
// Assumes: Avalon-MM byte addresses, one aligned 32-bit word per register
// Notes: Operation summary follows
//
// Operation
// - Receive FIFO holds three bytes; a byte arriving when full is lost, overflow flagged.
// - Data buffer writes go to transmit holding; reads return receive data only.
// - Enabled interrupt raised when transmit completes or a byte is received.
// - Transmit-done and receive flags stay set until software clears them.
// - Clearing the receive flag does nothing while bytes remain in the FIFO.
// - Baud timer is 16 bits, clocked via prescaler of 1, 4, 12 or 48.
// - Baud control holds generator enable, clock source select and prescaler select.
// - Port stays idle unless the baud generator is enabled.
// - Reload high and low bytes form the 16-bit reload value.
// - Timer counts up by one per selected clock tick from the reload value.
// - Overflow from ffff reloads the timer at once and gives the baud tick.
`ifndef SPBG_CONSTS_SVH
`define SPBG_CONSTS_SVH

// Register byte offsets
`define SPBG_OFF_DATA 5'h00
`define SPBG_OFF_CTRL 5'h04
`define SPBG_OFF_BAUD 5'h08
`define SPBG_OFF_RLDL 5'h0c
`define SPBG_OFF_RLDH 5'h10
`define SPBG_OFF_ISTAT 5'h14
`define SPBG_OFF_IMASK 5'h18

// Control/status field positions
`define SPBG_CTRL_TXDONE 0
`define SPBG_CTRL_RXRDY 1
`define SPBG_CTRL_OVF 2
`define SPBG_CTRL_TXBUSY 3
`define SPBG_CTRL_CNT_LO 4

// Baud control field positions
`define SPBG_BAUD_EN 0
`define SPBG_BAUD_SRC 1
`define SPBG_BAUD_PS_LO 2

// Interrupt status/mask bits
`define SPBG_IRQ_TX 0
`define SPBG_IRQ_RX 1
`define SPBG_IRQ_OVF 2

// Reset values
`define SPBG_RST_BAUD 4'h0
`define SPBG_RST_RELOAD 16'h0000
`define SPBG_RST_RLD_BYTE 8'h00
`define SPBG_RST_MASK 3'h0

// Prescaler divide counts and FIFO depth
`define SPBG_DIV1 6'h00
`define SPBG_DIV4 6'h03
`define SPBG_DIV12 6'h0b
`define SPBG_DIV48 6'h2f
`define SPBG_FIFO_DEPTH 2'h3
`define SPBG_TICKS_PER_BIT 1'h1

`endif

/* src/spbg_pkg.sv */
// Purpose: Types shared by the serial port modules
// Assumes: Nothing beyond the constants header
// Notes: States and prescaler select only; numbers live in the header
package spbg_pkg;
   typedef enum logic [1:0] {PS_DIV1, PS_DIV4, PS_DIV12, PS_DIV48} spbg_ps_e;
   typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} spbg_tx_e;
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} spbg_rx_e;
endpackage

/* src/spbg_top.sv */
// Purpose: Full-duplex serial port with Avalon-MM register access
// Assumes: Peer uses 8N1 framing at the programmed rate
// Notes: Reads take one wait cycle; writes complete at once
//
// Local design decisions: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`include "spbg_consts.svh"
module spbg_top
   import spbg_pkg::*;
(
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_rst_n,
   // Avalon-MM slave
   input wire logic [4:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   // Serial link
   input wire logic i_rxd,
   output logic o_txd,
   // Interrupt
   output logic o_irq
);

   spbg_baud_if bif ();

   logic [3:0] baud_ctrl;
   logic [7:0] reload_lo;
   logic [7:0] reload_hi;
   logic [2:0] irq_stat;
   logic [2:0] irq_mask;
   logic tx_done_flag;
   logic rx_ready_flag;
   logic ovf_flag;
   logic rd_pend;
   logic [7:0] tx_hold;
   logic tx_hold_vld;
   logic [7:0] tx_shift;
   logic [2:0] tx_bits;
   logic tx_half;
   spbg_tx_e tx_state;
   logic [2:0] rx_sync;
   logic rx_level;
   logic [7:0] rx_shift;
   logic [2:0] rx_bits;
   logic rx_half;
   spbg_rx_e rx_state;
   logic [7:0] fifo [0:2];
   logic [1:0] fifo_cnt;

   logic wr_acc;
   logic rd_acc;
   logic wr_lane;
   logic sel_data;
   logic sel_ctrl;
   logic sel_baud;
   logic sel_rldl;
   logic sel_rldh;
   logic sel_istat;
   logic sel_imask;
   logic [31:0] next_readdata;
   logic gen_on;
   logic tick;
   logic tx_load;
   logic tx_fin;
   logic rx_push;
   logic rx_pop;
   logic fifo_full;
   logic rx_lost;
   logic clr_txdone;
   logic clr_rxrdy;
   logic clr_ovf;

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode
   assign wr_acc = i_avs_write;
   assign rd_acc = i_avs_read & rd_pend;
   assign wr_lane = wr_acc & i_avs_byteenable[0];
   assign o_avs_waitrequest = i_avs_read & ~rd_pend;
   assign sel_data = (i_avs_address == `SPBG_OFF_DATA);
   assign sel_ctrl = (i_avs_address == `SPBG_OFF_CTRL);
   assign sel_baud = (i_avs_address == `SPBG_OFF_BAUD);
   assign sel_rldl = (i_avs_address == `SPBG_OFF_RLDL);
   assign sel_rldh = (i_avs_address == `SPBG_OFF_RLDH);
   assign sel_istat = (i_avs_address == `SPBG_OFF_ISTAT);
   assign sel_imask = (i_avs_address == `SPBG_OFF_IMASK);

   assign next_readdata =
      sel_data ? {24'h000000, fifo[0]} :
      sel_ctrl ? {26'h0000000, fifo_cnt, tx_state != TX_IDLE, ovf_flag,
                  rx_ready_flag, tx_done_flag} :
      sel_baud ? {28'h0000000, baud_ctrl} :
      sel_rldl ? {24'h000000, reload_lo} :
      sel_rldh ? {24'h000000, reload_hi} :
      sel_istat ? {29'h00000000, irq_stat} :
      sel_imask ? {29'h00000000, irq_mask} : 32'h00000000;

   // Read data sampled on the wait cycle, side effects on the accept edge
   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
      begin
         rd_pend <= 1'b0;
         o_avs_readdata <= 32'h00000000;
      end
      else
      begin
         rd_pend <= i_avs_read & ~rd_pend;
         if (i_avs_read && !rd_pend)
         begin
            o_avs_readdata <= next_readdata;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Baud registers
   assign gen_on = baud_ctrl[`SPBG_BAUD_EN];
   assign bif.enable = gen_on;
   assign bif.src_direct = baud_ctrl[`SPBG_BAUD_SRC];
   assign bif.prescale = spbg_ps_e'(baud_ctrl[`SPBG_BAUD_PS_LO +: 2]);
   assign bif.reload = {reload_hi, reload_lo};
   assign tick = bif.tick;

   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
      begin
         baud_ctrl <= `SPBG_RST_BAUD;
         reload_lo <= `SPBG_RST_RLD_BYTE;
         reload_hi <= `SPBG_RST_RLD_BYTE;
         irq_mask <= `SPBG_RST_MASK;
      end
      else if (wr_lane)
      begin
         if (sel_baud)
         begin
            baud_ctrl <= i_avs_writedata[3:0];
         end
         if (sel_rldl)
         begin
            reload_lo <= i_avs_writedata[7:0];
         end
         if (sel_rldh)
         begin
            reload_hi <= i_avs_writedata[7:0];
         end
         if (sel_imask)
         begin
            irq_mask <= i_avs_writedata[2:0];
         end
      end
   end

   spbg_baud u_baud
   (
      .i_mclk (i_mclk),
      .i_rst_n (i_rst_n),
      .bif (bif)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Transmitter
   // Data writes fill the holding byte
   // Start only on a tick so the start bit lasts two full ticks
   assign tx_load = gen_on & tx_hold_vld & (tx_state == TX_IDLE) & tick;
   assign tx_fin = (tx_state == TX_STOP) & tick & tx_half;

   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
      begin
         tx_hold <= 8'h00;
         tx_hold_vld <= 1'b0;
      end
      else if (wr_lane && sel_data)
      begin
         tx_hold <= i_avs_writedata[7:0];
         tx_hold_vld <= 1'b1;
      end
      else if (tx_load)
      begin
         tx_hold_vld <= 1'b0;
      end
   end

   // Start, eight data LSB first, stop
   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n || !gen_on)
      begin
         tx_state <= TX_IDLE;
         tx_shift <= 8'h00;
         tx_bits <= 3'h0;
         tx_half <= 1'b0;
         o_txd <= 1'b1;
      end
      else
      begin
         case (tx_state)
            TX_IDLE:
            begin
               o_txd <= 1'b1;
               tx_half <= 1'b0;
               if (tx_load)
               begin
                  tx_shift <= tx_hold;
                  tx_state <= TX_START;
                  o_txd <= 1'b0;
               end
            end
            TX_START, TX_DATA, TX_STOP:
            begin
               if (tick)
               begin
                  tx_half <= ~tx_half;
                  if (tx_half)
                  begin
                     if (tx_state == TX_START)
                     begin
                        o_txd <= tx_shift[0];
                        tx_bits <= 3'h0;
                        tx_state <= TX_DATA;
                     end
                     else if (tx_state == TX_DATA && tx_bits != 3'h7)
                     begin
                        o_txd <= tx_shift[1];
                        tx_shift <= {1'b0, tx_shift[7:1]};
                        tx_bits <= tx_bits + 3'h1;
                     end
                     else if (tx_state == TX_DATA)
                     begin
                        o_txd <= 1'b1;
                        tx_state <= TX_STOP;
                     end
                     else
                     begin
                        tx_state <= TX_IDLE;
                     end
                  end
               end
            end
            default:
            begin
               tx_state <= TX_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Receive pin synchroniser; level moves only when stages two and three agree
   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
      begin
         rx_sync <= 3'h7;
         rx_level <= 1'b1;
      end
      else
      begin
         rx_sync <= {rx_sync[1:0], i_rxd};
         if (rx_sync[1] == rx_sync[2])
         begin
            rx_level <= rx_sync[2];
         end
      end
   end

   // Receiver samples mid-bit: one tick after the start edge, then every two
   // Idle while generator is off
   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n || !gen_on)
      begin
         rx_state <= RX_IDLE;
         rx_shift <= 8'h00;
         rx_bits <= 3'h0;
         rx_half <= 1'b0;
      end
      else
      begin
         case (rx_state)
            RX_IDLE:
            begin
               rx_half <= 1'b0;
               if (!rx_level)
               begin
                  rx_state <= RX_START;
               end
            end
            RX_START:
            begin
               if (tick)
               begin
                  rx_bits <= 3'h0;
                  rx_half <= 1'b0;
                  rx_state <= rx_level ? RX_IDLE : RX_DATA;
               end
            end
            RX_DATA:
            begin
               if (tick)
               begin
                  rx_half <= ~rx_half;
                  if (rx_half)
                  begin
                     rx_shift <= {rx_level, rx_shift[7:1]};
                     rx_bits <= rx_bits + 3'h1;
                     rx_half <= 1'b0;
                     if (rx_bits == 3'h7)
                     begin
                        rx_state <= RX_STOP;
                     end
                  end
               end
            end
            RX_STOP:
            begin
               if (tick)
               begin
                  rx_half <= ~rx_half;
                  if (rx_half)
                  begin
                     rx_state <= RX_IDLE;
                  end
               end
            end
            default:
            begin
               rx_state <= RX_IDLE;
            end
         endcase
      end
   end

   // Framing error drops the byte rather than storing garbage
   assign rx_push = (rx_state == RX_STOP) & tick & rx_half & rx_level;

   ////////////////////////////////////////////////////////////////////////////
   // Three-byte receive FIFO
   assign rx_pop = rd_acc & sel_data & (fifo_cnt != 2'h0);
   assign fifo_full = (fifo_cnt == `SPBG_FIFO_DEPTH);
   assign rx_lost = rx_push & fifo_full & ~rx_pop;

   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
      begin
         fifo_cnt <= 2'h0;
         fifo[0] <= 8'h00;
         fifo[1] <= 8'h00;
         fifo[2] <= 8'h00;
      end
      else if (rx_pop)
      begin
         fifo[0] <= fifo[1];
         fifo[1] <= fifo[2];
         if (rx_push)
         begin
            fifo[fifo_cnt - 2'h1] <= rx_shift;
         end
         else
         begin
            fifo_cnt <= fifo_cnt - 2'h1;
         end
      end
      else if (rx_push && !fifo_full)
      begin
         fifo[fifo_cnt] <= rx_shift;
         fifo_cnt <= fifo_cnt + 2'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Flags cleared by writing zero
   assign clr_txdone = wr_lane & sel_ctrl & ~i_avs_writedata[`SPBG_CTRL_TXDONE];
   assign clr_ovf = wr_lane & sel_ctrl & ~i_avs_writedata[`SPBG_CTRL_OVF];
   assign clr_rxrdy = wr_lane & sel_ctrl & ~i_avs_writedata[`SPBG_CTRL_RXRDY] &
                      (fifo_cnt == 2'h0);

   // Set wins over a clear in the same cycle
   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
      begin
         tx_done_flag <= 1'b0;
         rx_ready_flag <= 1'b0;
         ovf_flag <= 1'b0;
      end
      else
      begin
         tx_done_flag <= tx_fin | (tx_done_flag & ~clr_txdone);
         rx_ready_flag <= rx_push | (fifo_cnt != 2'h0) | (rx_ready_flag & ~clr_rxrdy);
         ovf_flag <= rx_lost | (ovf_flag & ~clr_ovf);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Event status, read to clear, masked onto one line
   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
      begin
         irq_stat <= 3'h0;
      end
      else
      begin
         irq_stat <= {rx_lost, rx_push, tx_fin} |
                     (irq_stat & ~((rd_acc && sel_istat) ? o_avs_readdata[2:0] : 3'h0));
      end
   end

   assign o_irq = |(irq_stat & irq_mask);

endmodule // spbg_top
